// >>> verilog/pca_pkg.sv
// Constants, register map and state types of the dual counter array.
// Assumes an 8-bit special function register port on the core clock.
package pca_pkg;

  // ****************************************************************
  // Register map: two-entry tables indexed by array 0..1, six-entry tables by module 0..5
  // ****************************************************************
  localparam logic [7:0] CNT_L_ADR [2] = '{8'ha2, 8'hba};
  localparam logic [7:0] CNT_H_ADR [2] = '{8'ha3, 8'hbb};
  localparam logic [7:0] CTL_ADR   [2] = '{8'ha4, 8'hbc};
  localparam logic [7:0] PER_ADR   [2] = '{8'hb4, 8'hc7};
  localparam logic [7:0] PRE_ADR   [2] = '{8'hfb, 8'hfc};
  localparam logic [7:0] STAT_ADR      = 8'ha5;
  localparam logic [7:0] MODE_ADR  [6] = '{8'ha9, 8'haa, 8'hab,
                                           8'hbd, 8'hbe, 8'hbf};
  localparam logic [7:0] CMPL_ADR  [6] = '{8'hac, 8'haf, 8'hb2,
                                           8'hc1, 8'hc3, 8'hc5};
  localparam logic [7:0] CMPH_ADR  [6] = '{8'had, 8'hb1, 8'hb3,
                                           8'hc2, 8'hc4, 8'hc6};

  // ****************************************************************
  // Field positions and codes
  // ****************************************************************
  localparam int CTL_ALL  = 7;
  localparam int CTL_RUN  = 6;
  localparam int CTL_OVFI = 5;
  localparam int CTL_IDLE = 4;
  localparam logic [1:0] SEL_PRE = 2'h0;
  localparam logic [1:0] SEL_T0  = 2'h1;
  localparam logic [1:0] SEL_EXT = 2'h2;
  localparam int PRE_CE = 4;
  localparam logic [7:0] PRE_RST = 8'h10;
  localparam int MD_ECOMP = 7;
  localparam int MD_POS   = 6;
  localparam int MD_NEG   = 5;
  localparam int MD_TOG   = 4;
  localparam int MD_IE    = 3;
  localparam logic [2:0] PWM_NONE = 3'h0;
  localparam logic [2:0] PWM_FIX8 = 3'h1;
  localparam logic [2:0] PWM_PRG8 = 3'h2;
  localparam logic [2:0] PWM_FIX16 = 3'h3;
  // Status: flags of modules 0..2 at 2:0, overflow 0 at 3,
  // flags of modules 3..5 at 6:4, overflow 1 at 7
  localparam int ST_OVF [2] = '{3, 7};
  localparam int ST_TCM [6] = '{0, 1, 2, 4, 5, 6};

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [4:0] {
    PCA_FN_OFF = 5'b00001,
    PCA_FN_CAP = 5'b00010,
    PCA_FN_TMR = 5'b00100,
    PCA_FN_TOG = 5'b01000,
    PCA_FN_PWM = 5'b10000
  } pca_fn_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } pca_sfr_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0]  ctl;
    logic [7:0]  pre;
    logic [7:0]  per;
    logic [7:0]  per_act;
    logic [14:0] div;
  } pca_blk_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] lo;
    logic [7:0] hi;
    logic       pin_o;
  } pca_tcm_t;

  typedef struct packed {
    pca_blk_t [1:0] blk;
    pca_tcm_t [5:0] timer_counter_module;
    logic [7:0]     stat;
    logic [7:0]     rdata;
    logic [1:0]     irq;
    logic [5:0]     pin_oe;
    logic [5:0]     pin_s1;
    logic [5:0]     pin_s2;
    logic [5:0]     pin_d;
    logic [1:0]     ext_s1;
    logic [1:0]     ext_s2;
    logic [1:0]     ext_d;
  } pca_state_t;

endpackage

// >>> verilog/pca_top.sv
// Dual programmable counter array with capture, compare, toggle, PWM.
// Assumes a core that writes and reads byte registers on clk and
// pins that arrive asynchronously; timer 0 overflow is a clk pulse.
//
// Operation
// - Two arrays, each one shared 16-bit counter
// - Each module: capture, timer, toggle or PWM
// - Counter free-runs except programmable-period PWM
// - Control field picks prescaler, timer0, external pin
// - Prescaler divides clock by two to exponent
// - Prescaler bit 4 enables; resets enabled, divide one
// - Capture, timer, toggle interrupt; PWM does not
// - One pin per module, released when unused
// - Capture counter on rising, falling or both
// - Capture load requests enabled interrupt
// - Timer compares 16-bit counter, interrupts on match
// - Toggle inverts pin on each match
// - Fixed 8-bit PWM period is 256 counts
// - Fixed 8-bit PWM high when low byte >= duty
// - Low-byte overflow copies high duty to low
// - Counter bytes readable and writable separately
// - One period register per array
// - One status register holds both arrays' flags
// - Control holds run, overflow, idle, clock select
// - Period match clears counter, reloads period, duty
// - Low write clears comparator enable, high sets
`timescale 1ns/1ps
module pca_top
  import pca_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Register port
  input  wire pca_pkg::pca_sfr_t sfr,
  output logic [7:0]            sfr_rdata,
  // Core status and timer 0
  input  wire logic             cpu_idle,
  input  wire logic             timer0_ovf,
  // Pins
  input  wire logic [1:0]       ext_clk_pin,
  input  wire logic [5:0]       tcm_pin_in,
  output logic [5:0]            tcm_pin_out,
  output logic [5:0]            tcm_pin_oe,
  // Interrupt requests, one per array
  output logic [1:0]            irq
);
  import pca_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_n;
  logic rst_q_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_n <= 1'b0;
      rst_q_n  <= 1'b0;
    end else begin
      rst_s1_n <= 1'b1;
      rst_q_n  <= rst_s1_n;
    end
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  pca_state_t  s_r;
  pca_state_t  s_nxt;
  logic [1:0]  tick;
  logic [1:0]  inc;
  logic [1:0]  prog;
  logic [1:0]  low_ovf;
  logic [1:0]  reload;
  logic [1:0]  wrap;
  logic [15:0] cnt_n [2];
  pca_fn_t     fn [6];
  logic [5:0]  match;
  logic [5:0]  edge_hit;
  logic [5:0]  ev;

  function automatic pca_fn_t decode(input logic [7:0] md);
    if (md[2:0] != PWM_NONE) return PCA_FN_PWM;
    if (md[MD_TOG]) return PCA_FN_TOG;
    if (md[MD_POS] | md[MD_NEG]) return PCA_FN_CAP;
    if (md[MD_ECOMP]) return PCA_FN_TMR;
    return PCA_FN_OFF;
  endfunction

  always_comb begin
    logic [14:0] mask;
    logic        src;
    logic        run;
    logic [7:0]  st_set;
    logic [7:0]  st_clr;
    int          b;
    mask   = '0;
    src    = 1'b0;
    run    = 1'b0;
    st_set = '0;
    st_clr = '0;
    b      = 0;
    s_nxt  = s_r;
    // Pin and clock synchronisers
    s_nxt.pin_s1 = tcm_pin_in;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_d  = s_r.pin_s2;
    s_nxt.ext_s1 = ext_clk_pin;
    s_nxt.ext_s2 = s_r.ext_s1;
    s_nxt.ext_d  = s_r.ext_s2;
    // Counters, one per array
    for (int a = 0; a < 2; a++) begin
      s_nxt.blk[a].div = s_r.blk[a].div + 15'h0001;
      mask = 15'((16'h0001 << s_r.blk[a].pre[3:0]) - 16'h0001);
      tick[a] = s_r.blk[a].pre[PRE_CE] &&
                ((s_r.blk[a].div & mask) == mask);
      unique case (s_r.blk[a].ctl[1:0])
        SEL_PRE: src = tick[a];
        SEL_T0:  src = timer0_ovf;
        SEL_EXT: src = s_r.ext_s2[a] & ~s_r.ext_d[a];
        default: src = 1'b0;
      endcase
      run = (s_r.blk[a].ctl[CTL_RUN] | s_r.blk[0].ctl[CTL_ALL] |
             s_r.blk[1].ctl[CTL_ALL]) &
            ~(cpu_idle & s_r.blk[a].ctl[CTL_IDLE]);
      inc[a]  = run & src;
      prog[a] = 1'b0;
      for (int k = 0; k < 3; k++)
        prog[a] |= (s_r.timer_counter_module[3*a+k].mode[2:0] == PWM_PRG8);
      reload[a]  = inc[a] & prog[a] &
                   (s_r.blk[a].cnt[7:0] == s_r.blk[a].per_act);
      low_ovf[a] = inc[a] & ~prog[a] &
                   (s_r.blk[a].cnt[7:0] == 8'hff);
      wrap[a]    = inc[a] & ~prog[a] &
                   (s_r.blk[a].cnt == 16'hffff);
      cnt_n[a] = s_r.blk[a].cnt;
      if (reload[a]) begin
        cnt_n[a] = 16'h0000;
        s_nxt.blk[a].per_act = s_r.blk[a].per;
      end else if (inc[a]) begin
        cnt_n[a] = s_r.blk[a].cnt + 16'h0001;
      end
      s_nxt.blk[a].cnt = cnt_n[a];
      if (wrap[a])
        st_set[ST_OVF[a]] = 1'b1;
    end
    // Timer/counter modules
    for (int m = 0; m < 6; m++) begin
      b = m / 3;
      fn[m] = decode(s_r.timer_counter_module[m].mode);
      edge_hit[m] =
        (s_r.timer_counter_module[m].mode[MD_POS] & s_r.pin_s2[m] & ~s_r.pin_d[m]) |
        (s_r.timer_counter_module[m].mode[MD_NEG] & ~s_r.pin_s2[m] & s_r.pin_d[m]);
      match[m] = s_r.timer_counter_module[m].mode[MD_ECOMP] & inc[b] &
                 (cnt_n[b] == {s_r.timer_counter_module[m].hi, s_r.timer_counter_module[m].lo});
      ev[m] = 1'b0;
      s_nxt.pin_oe[m] = 1'b0;
      unique case (fn[m])
        PCA_FN_CAP: begin
          if (edge_hit[m]) begin
            {s_nxt.timer_counter_module[m].hi, s_nxt.timer_counter_module[m].lo} = s_r.blk[b].cnt;
            ev[m] = 1'b1;
          end
        end
        PCA_FN_TMR: ev[m] = match[m];
        PCA_FN_TOG: begin
          s_nxt.pin_oe[m] = 1'b1;
          if (match[m]) begin
            s_nxt.timer_counter_module[m].pin_o = ~s_r.timer_counter_module[m].pin_o;
            ev[m] = 1'b1;
          end
        end
        PCA_FN_PWM: begin
          s_nxt.pin_oe[m] = 1'b1;
          if (s_r.timer_counter_module[m].mode[2:0] == PWM_FIX16)
            s_nxt.timer_counter_module[m].pin_o = s_r.timer_counter_module[m].mode[MD_ECOMP] &&
              (s_r.blk[b].cnt >= {s_r.timer_counter_module[m].hi, s_r.timer_counter_module[m].lo});
          else
            s_nxt.timer_counter_module[m].pin_o = s_r.timer_counter_module[m].mode[MD_ECOMP] &&
              (s_r.blk[b].cnt[7:0] >= s_r.timer_counter_module[m].lo);
          if (low_ovf[b] || reload[b])
            s_nxt.timer_counter_module[m].lo = s_r.timer_counter_module[m].hi;
        end
        default: ;
      endcase
      if (ev[m])
        st_set[ST_TCM[m]] = 1'b1;
      if (!s_nxt.pin_oe[m])
        s_nxt.timer_counter_module[m].pin_o = 1'b0;
    end
    // Register writes take precedence over counting
    if (sfr.wr) begin
      for (int a = 0; a < 2; a++) begin
        if (sfr.addr == CNT_L_ADR[a])
          s_nxt.blk[a].cnt[7:0] = sfr.wdata;
        if (sfr.addr == CNT_H_ADR[a])
          s_nxt.blk[a].cnt[15:8] = sfr.wdata;
        if (sfr.addr == CTL_ADR[a])
          s_nxt.blk[a].ctl = sfr.wdata & 8'hf7;
        if (sfr.addr == PER_ADR[a])
          s_nxt.blk[a].per = sfr.wdata;
        if (sfr.addr == PRE_ADR[a])
          s_nxt.blk[a].pre = sfr.wdata & 8'h1f;
      end
      for (int m = 0; m < 6; m++) begin
        if (sfr.addr == MODE_ADR[m])
          s_nxt.timer_counter_module[m].mode = sfr.wdata;
        if (sfr.addr == CMPL_ADR[m]) begin
          s_nxt.timer_counter_module[m].lo = sfr.wdata;
          s_nxt.timer_counter_module[m].mode[MD_ECOMP] = 1'b0;
        end
        if (sfr.addr == CMPH_ADR[m]) begin
          s_nxt.timer_counter_module[m].hi = sfr.wdata;
          s_nxt.timer_counter_module[m].mode[MD_ECOMP] = 1'b1;
        end
      end
      if (sfr.addr == STAT_ADR)
        st_clr = ~sfr.wdata;
    end
    // Flags: writing zero clears, a new event in that cycle wins
    s_nxt.stat = (s_r.stat & ~st_clr) | st_set;
    for (int a = 0; a < 2; a++) begin
      s_nxt.irq[a] = s_nxt.stat[ST_OVF[a]] &
                     s_r.blk[a].ctl[CTL_OVFI];
      for (int k = 0; k < 3; k++)
        s_nxt.irq[a] |= s_nxt.stat[ST_TCM[3*a+k]] &
                        s_r.timer_counter_module[3*a+k].mode[MD_IE];
    end
    // Read data follows the address one clock later
    s_nxt.rdata = 8'h00;
    for (int a = 0; a < 2; a++) begin
      if (sfr.addr == CNT_L_ADR[a]) s_nxt.rdata = s_r.blk[a].cnt[7:0];
      if (sfr.addr == CNT_H_ADR[a]) s_nxt.rdata = s_r.blk[a].cnt[15:8];
      if (sfr.addr == CTL_ADR[a])   s_nxt.rdata = s_r.blk[a].ctl;
      if (sfr.addr == PER_ADR[a])   s_nxt.rdata = s_r.blk[a].per;
      if (sfr.addr == PRE_ADR[a])   s_nxt.rdata = s_r.blk[a].pre;
    end
    for (int m = 0; m < 6; m++) begin
      if (sfr.addr == MODE_ADR[m]) s_nxt.rdata = s_r.timer_counter_module[m].mode;
      if (sfr.addr == CMPL_ADR[m]) s_nxt.rdata = s_r.timer_counter_module[m].lo;
      if (sfr.addr == CMPH_ADR[m]) s_nxt.rdata = s_r.timer_counter_module[m].hi;
    end
    if (sfr.addr == STAT_ADR) s_nxt.rdata = s_r.stat;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      s_r            <= '0;
      s_r.blk[0].pre <= PRE_RST;
      s_r.blk[1].pre <= PRE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata = s_r.rdata;
  assign irq       = s_r.irq;
  assign tcm_pin_oe = s_r.pin_oe;
  always_comb
    for (int m = 0; m < 6; m++)
      tcm_pin_out[m] = s_r.timer_counter_module[m].pin_o;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_q_n);

  for (genvar a = 0; a < 2; a++) begin : g_blk
    sequence s_quiet;
      !sfr.wr;
    endsequence
    sequence s_step;
      inc[a] && !prog[a] && s_r.blk[a].cnt != 16'hffff ##0 s_quiet;
    endsequence
    cnt_step_a: assert property (s_step |=>
      s_r.blk[a].cnt == $past(s_r.blk[a].cnt) + 16'h0001)
      else $error("counter did not advance by one");
    cnt_wrap_a: assert property (wrap[a] ##0 s_quiet |=>
      s_r.blk[a].cnt == 16'h0000 && s_r.stat[ST_OVF[a]])
      else $error("counter wrap lost or flag not set");
    pre_gate_a: assert property (!s_r.blk[a].pre[PRE_CE] |-> !tick[a])
      else $error("prescaler ticked while disabled");
    pre_half_a: assert property (
      s_r.blk[a].pre[4:0] == 5'h11 && tick[a] |=> !tick[a])
      else $error("divide by two ticked twice in a row");
    prg_clear_a: assert property (reload[a] ##0 s_quiet |=>
      s_r.blk[a].cnt == 16'h0000 &&
      s_r.blk[a].per_act == $past(s_r.blk[a].per))
      else $error("period match did not clear and reload");

    // Idle stop: the core sleeping with the idle bit set freezes counting
    sequence s_idle;
      cpu_idle && s_r.blk[a].ctl[CTL_IDLE];
    endsequence
    idle_stop_a: assert property (s_idle |-> !inc[a])
      else $error("counter ran while core idle");

    // Code 3 of the clock field selects no source at all
    sel_none_a: assert property (s_r.blk[a].ctl[1:0] == 2'h3 |->
      !inc[a])
      else $error("counter ran with no clock selected");

    // Programmable period replaces the wrap, so no overflow flag
    prg_noovf_a: assert property (prog[a] |-> !wrap[a])
      else $error("overflow flagged in programmable period");

    // A stopped counter holds its value unless software writes it
    run_hold_a: assert property (!inc[a] ##0 s_quiet |=>
      s_r.blk[a].cnt == $past(s_r.blk[a].cnt))
      else $error("counter moved without a clock pulse");
  end

  for (genvar m = 0; m < 6; m++) begin : g_tcm
    localparam int B = m / 3;
    sequence s_hit;
      fn[m] == PCA_FN_TOG && match[m];
    endsequence
    cap_load_a: assert property (
      fn[m] == PCA_FN_CAP && edge_hit[m] && !sfr.wr |=>
      {s_r.timer_counter_module[m].hi, s_r.timer_counter_module[m].lo} == $past(s_r.blk[B].cnt) &&
      s_r.stat[ST_TCM[m]])
      else $error("capture did not load counter");
    tog_flip_a: assert property (s_hit |=>
      s_r.timer_counter_module[m].pin_o != $past(s_r.timer_counter_module[m].pin_o))
      else $error("toggle output did not invert");
    pwm_quiet_a: assert property (fn[m] == PCA_FN_PWM |-> !ev[m])
      else $error("PWM raised a module event");
    pwm_load_a: assert property (
      fn[m] == PCA_FN_PWM && low_ovf[B] && !sfr.wr |=>
      s_r.timer_counter_module[m].lo == $past(s_r.timer_counter_module[m].hi))
      else $error("duty not copied at low-byte overflow");
    ecomp_low_a: assert property (
      sfr.wr && sfr.addr == CMPL_ADR[m] |=>
      !s_r.timer_counter_module[m].mode[MD_ECOMP])
      else $error("low compare write left comparator on");
    pin_free_a: assert property (
      fn[m] != PCA_FN_TOG && fn[m] != PCA_FN_PWM |=> !tcm_pin_oe[m])
      else $error("pin driven while not assigned");

    // Timer match raises the module flag
    sequence s_tmr;
      fn[m] == PCA_FN_TMR && match[m] && !sfr.wr;
    endsequence
    tmr_flag_a: assert property (s_tmr |=> s_r.stat[ST_TCM[m]])
      else $error("timer match did not set flag");

    // Wide PWM: high while the full counter is at or above duty
    sequence s_wide;
      fn[m] == PCA_FN_PWM && s_r.timer_counter_module[m].mode[2:0] == PWM_FIX16 &&
      s_r.timer_counter_module[m].mode[MD_ECOMP] && !sfr.wr;
    endsequence
    pwm_wide_a: assert property (s_wide |=>
      tcm_pin_out[m] == ($past(s_r.blk[B].cnt) >=
                         {$past(s_r.timer_counter_module[m].hi), $past(s_r.timer_counter_module[m].lo)}))
      else $error("wide PWM level wrong");
  end

endmodule

// >>> tb/pca_pin_model.sv
// External clock source that stands on the far side of a counter pin.
// Assumes the bench raises run for bursts of several eight-cycle periods.
`timescale 1ns/1ps
module pca_pin_model (
  // Clock and control
  input  wire logic clk,
  input  wire logic run,
  // Pin
  output logic      pin
);
  logic [1:0] cnt_r;

  // ****************************************************************
  // Toggle every four cycles, so the rate stays under a quarter clock
  // ****************************************************************
  initial begin
    cnt_r = 2'h0;
    pin   = 1'b0;
  end
  always @(posedge clk) begin
    if (run) begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == 2'h3) begin
        pin <= ~pin;
      end
    end else begin
      // Still between bursts
      cnt_r <= 2'h0;
      pin   <= 1'b0;
    end
  end
endmodule

// >>> tb/test_pca_top.sv
// Self-checking bench of the dual counter array over its byte registers.
// Assumes the register port, pins and the pin model named below.
`timescale 1ns/1ps
module test_pca_top;
  import pca_pkg::*;
  logic       clk, reset_n, cpu_idle, timer0_ovf, ext_run, ext1;
  pca_sfr_t   sfr;
  logic [7:0] sfr_rdata, v;
  logic [1:0] ext_clk_pin, irq;
  logic [5:0] tcm_pin_in, tcm_pin_out, tcm_pin_oe;
  int         mismatches, cmp_count, cycles, hi;

  assign ext_clk_pin = {ext1, 1'b0};

  pca_top pca_top_inst (.clk(clk), .reset_n(reset_n), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .timer0_ovf(timer0_ovf),
    .ext_clk_pin(ext_clk_pin), .tcm_pin_in(tcm_pin_in),
    .tcm_pin_out(tcm_pin_out), .tcm_pin_oe(tcm_pin_oe), .irq(irq));
  pca_pin_model pca_pin_model_inst (.clk(clk), .run(ext_run), .pin(ext1));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{a, 1'b1, d};
    @(posedge clk);
    sfr.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sfr <= '{a, 1'b0, 8'h00};
    repeat (2) @(posedge clk);
    #1 v = sfr_rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock and timeout
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    reset_n = 1'b0; cpu_idle = 1'b0; timer0_ovf = 1'b0; ext_run = 1'b0;
    sfr = '0; tcm_pin_in = 6'h00;
    wt(2);
    reset_n <= 1'b1;
    wt(3);
    rd(PRE_ADR[0]); chk(v, PRE_RST);
    rd(PRE_ADR[1]); chk(v, PRE_RST);
    rd(CTL_ADR[0]); chk(v, 8'h00);
    rd(8'h00); chk(v, 8'h00);
    wr(CNT_L_ADR[0], 8'h34); wr(CNT_H_ADR[0], 8'h12);
    rd(CNT_L_ADR[0]); chk(v, 8'h34);
    rd(CNT_H_ADR[0]); chk(v, 8'h12);
    // Wrap through all ones
    wr(CNT_L_ADR[0], 8'hfc); wr(CNT_H_ADR[0], 8'hff);
    wr(CTL_ADR[0], 8'h40); wt(10); wr(CTL_ADR[0], 8'h00);
    rd(STAT_ADR); chk(v, 8'h08);
    rd(CNT_H_ADR[0]); chk(v, 8'h00);
    wr(STAT_ADR, 8'h00); rd(STAT_ADR); chk(v, 8'h00);
    wr(CTL_ADR[0], 8'h3b); rd(CTL_ADR[0]); chk(v, 8'h33);
    // Prescaler divide by four, then gated off
    wr(CTL_ADR[0], 8'h00); wr(CNT_L_ADR[0], 8'h00); wr(CNT_H_ADR[0], 8'h00);
    wr(PRE_ADR[0], 8'hf2); rd(PRE_ADR[0]); chk(v, 8'h12);
    wr(CTL_ADR[0], 8'h40); wt(40); wr(CTL_ADR[0], 8'h00);
    rd(CNT_L_ADR[0]); chk(8'(v >= 8'h09 && v <= 8'h0c), 8'h01);
    wr(PRE_ADR[0], 8'h02); wr(CNT_L_ADR[0], 8'h00);
    wr(CTL_ADR[0], 8'h40); wt(20); wr(CTL_ADR[0], 8'h00);
    rd(CNT_L_ADR[0]); chk(v, 8'h00);
    wr(PRE_ADR[0], 8'h10);
    // Toggle with interrupt, comparator enable by byte order
    wr(MODE_ADR[0], 8'h18); wr(CMPL_ADR[0], 8'h20); wr(CMPH_ADR[0], 8'h00);
    rd(MODE_ADR[0]); chk(v, 8'h98);
    wr(CMPL_ADR[0], 8'h20); rd(MODE_ADR[0]); chk(v, 8'h18);
    wr(CMPH_ADR[0], 8'h00); wr(CNT_L_ADR[0], 8'h00);
    wr(CTL_ADR[0], 8'h40); wt(40); wr(CTL_ADR[0], 8'h00);
    chk(8'(tcm_pin_oe[0]), 8'h01);
    chk(8'(tcm_pin_out[0]), 8'h01);
    chk(8'(irq), 8'h01);
    rd(STAT_ADR); chk(v, 8'h01);
    wr(STAT_ADR, 8'h00); wr(MODE_ADR[0], 8'h00); rd(STAT_ADR);
    chk(8'(irq), 8'h00);
    chk(8'(tcm_pin_oe[0]), 8'h00);
    // Capture on rising edge only
    wr(MODE_ADR[1], 8'h48); wr(CNT_L_ADR[0], 8'h00);
    wr(CTL_ADR[0], 8'h40); wt(20);
    tcm_pin_in[1] <= 1'b1; wt(10);
    chk(8'(irq), 8'h01);
    tcm_pin_in[1] <= 1'b0; wt(10); wr(CTL_ADR[0], 8'h00);
    rd(CMPL_ADR[1]); chk(8'(v >= 8'h14 && v <= 8'h20), 8'h01);
    rd(STAT_ADR); chk(v, 8'h02);
    wr(STAT_ADR, 8'h00); wr(MODE_ADR[1], 8'h00);
    // Fixed 8-bit PWM at half duty
    wr(CMPL_ADR[2], 8'h00); wr(CMPH_ADR[2], 8'h80); wr(MODE_ADR[2], 8'h81);
    wr(CNT_L_ADR[0], 8'h00); wr(CTL_ADR[0], 8'h40); wt(300);
    hi = 0;
    repeat (256) begin
      @(posedge clk);
      #1 hi += int'(tcm_pin_out[2]);
    end
    chk(8'(hi), 8'h80);
    chk(8'(tcm_pin_oe[2]), 8'h01);
    rd(CMPL_ADR[2]); chk(v, 8'h80);
    rd(STAT_ADR); chk(v, 8'h00);
    wr(CTL_ADR[0], 8'h00);
    // Programmable-period PWM on all three modules
    wr(PER_ADR[0], 8'h10);
    for (int m = 0; m < 3; m++) begin
      wr(CMPH_ADR[m], 8'h08); wr(MODE_ADR[m], 8'h82);
    end
    wr(CNT_L_ADR[0], 8'h00); wr(CNT_H_ADR[0], 8'h00); wr(CTL_ADR[0], 8'h40);
    repeat (6) begin
      rd(CNT_L_ADR[0]); chk(8'(v <= 8'h10), 8'h01);
      wt(7);
    end
    rd(CNT_H_ADR[0]); chk(v, 8'h00);
    wr(CTL_ADR[0], 8'h00);
    // Array one on timer 0 overflow pulses
    wr(CTL_ADR[1], 8'h41);
    repeat (5) begin
      @(posedge clk) timer0_ovf <= 1'b1;
      @(posedge clk) timer0_ovf <= 1'b0;
    end
    wt(3); wr(CTL_ADR[1], 8'h00);
    rd(CNT_L_ADR[1]); chk(v, 8'h05);
    // Idle stop, then run-both from array zero's control
    wr(CNT_L_ADR[1], 8'h00); cpu_idle <= 1'b1;
    wr(CTL_ADR[1], 8'h50); wt(10); wr(CTL_ADR[1], 8'h00);
    rd(CNT_L_ADR[1]); chk(v, 8'h00);
    cpu_idle <= 1'b0;
    wr(CTL_ADR[0], 8'h80); wt(10); wr(CTL_ADR[0], 8'h00);
    rd(CNT_L_ADR[1]); chk(8'(v >= 8'h0a && v <= 8'h10), 8'h01);
    wr(CNT_L_ADR[1], 8'h00); wr(CTL_ADR[1], 8'h42);
    @(posedge clk) ext_run <= 1'b1;
    wt(50);
    ext_run <= 1'b0;
    wt(5); wr(CTL_ADR[1], 8'h00);
    rd(CNT_L_ADR[1]); chk(v, 8'h06);
    end_sim();
  end
endmodule
